//--- logic/dvm_blend.sv
// Purpose: per-plane alpha blend of two pixels
// Assumes: planes are PB bits each
// Notes:   purely combinational, result registered by the caller
`timescale 1ns/1ps
module dvm_blend #(
  parameter int unsigned PB = 8,
  parameter int unsigned NP = 3
) (
  dvm_blend_if.dp bi
);
  genvar g;
  generate
    for (g = 0; g < NP; g++) begin : g_pl
      wire [PB+8:0] mix = bi.a[g*PB +: PB] * (9'h100 - {1'b0, bi.alpha})
                        + bi.b[g*PB +: PB] * {1'b0, bi.alpha};
      assign bi.y[g*PB +: PB] = bi.use_b ? mix[PB+7:8] : bi.a[g*PB +: PB];
    end
  endgenerate
endmodule

//--- logic/dvm_blend_if.sv
// Purpose: carrier between the mixer control and its blend datapath
// Assumes: single clock
// Notes:   none
`timescale 1ns/1ps
interface dvm_blend_if #(parameter int unsigned W = 24);
  logic [W-1:0] a;
  logic [W-1:0] b;
  logic         use_b;
  logic [7:0]   alpha;
  logic [W-1:0] y;
  modport ctl (output a, b, use_b, alpha, input y);
  modport dp  (input a, b, use_b, alpha, output y);
endinterface

//--- logic/dvm_mixer.sv
// Purpose: two-input video mixer stream flow with packet end handling
// Assumes: valid/ready streams on one clock; APB register access
// Notes:   one output register stage; words pass only when all parties move
// Functional notes
// - Keep consuming a packet until end-of-packet arrives on either input.
// - Frame length is never checked against control packet dimensions.
// - End-of-packet on either input ends the output frame with end-of-packet.
// - With both inputs on, drop leftover second-input words until its end-of-packet.
// - Ready may drop between packets, and inside one while the output slot or the other enabled input stalls.
// - Throughput follows planes and pixels per beat settings.
// - Backpressure keeps all ports moving at the slowest interface rate.
`timescale 1ns/1ps
module dvm_mixer
  import dvm_pkg::*;
#(
  parameter int unsigned PIX_BITS = DVM_PIX_BITS,
  parameter int unsigned PLANES   = DVM_PLANES,
  parameter int unsigned PPB      = DVM_PIX_PER_BT,
  parameter int unsigned W        = PIX_BITS * PLANES * PPB
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         rst,
  // APB slave
  input  wire logic         psel,
  input  wire logic         penable,
  input  wire logic         pwrite,
  input  wire logic [7:0]   paddr,
  input  wire logic [31:0]  pwdata,
  output logic              pready,
  output logic [31:0]       prdata,
  output logic              pslverr,
  // First video input
  input  wire logic [W-1:0] first_video_input_data,
  input  wire logic         first_video_input_valid,
  input  wire logic         first_video_input_sop,
  input  wire logic         first_video_input_eop,
  output logic              first_video_input_ready,
  // Second video input
  input  wire logic [W-1:0] second_video_input_data,
  input  wire logic         second_video_input_valid,
  input  wire logic         second_video_input_sop,
  input  wire logic         second_video_input_eop,
  output logic              second_video_input_ready,
  // Output stream
  output logic [W-1:0]      dout_data,
  output logic              dout_valid,
  output logic              dout_sop,
  output logic              dout_eop,
  input  wire logic         dout_ready
);
  localparam int unsigned GW = $clog2(DVM_GAP_CYCLES + 1);

  dvm_state_t  st_q, st_d;
  logic [31:0] ctrl_q;
  logic [31:0] frames_q;
  logic [31:0] drops_q;
  logic [GW-1:0] gap_q;
  logic        a_ready_q, b_ready_q;
  logic [W-1:0] dout_data_q;
  logic        dout_valid_q, dout_sop_q, dout_eop_q;
  logic        pready_q, pslverr_q;
  logic [31:0] prdata_q;

  dvm_blend_if #(.W(W)) bi ();
  dvm_blend #(.PB(PIX_BITS), .NP(PLANES * PPB)) u_blend (.bi(bi));

  wire go       = ctrl_q[DVM_CTRL_GO];
  wire en2      = ctrl_q[DVM_CTRL_EN2];
  // Output slot frees when empty or being taken downstream
  wire out_free = !dout_valid_q || dout_ready;
  wire both_v   = first_video_input_valid && (!en2 || second_video_input_valid);
  // Joint transfer: every enabled input present and output able to take it
  wire mv       = (st_q == DVM_PASS) && both_v && out_free
                  && a_ready_q && (!en2 || b_ready_q);
  wire a_eop    = mv && first_video_input_eop;
  wire b_eop    = mv && en2 && second_video_input_eop;
  wire end_frm  = a_eop || b_eop;
  // Leftover second-input words are taken and thrown away
  wire drop_b   = (st_q == DVM_DRAIN) && second_video_input_valid && b_ready_q;
  // A frame starts only once every enabled input offers a word
  wire start_ok = (st_q == DVM_IDLE) && go && first_video_input_valid
                  && (!en2 || second_video_input_valid);

  assign bi.a     = first_video_input_data;
  assign bi.b     = second_video_input_data;
  // Second input only blends in while it is enabled
  assign bi.use_b = en2;
  assign bi.alpha = ctrl_q[DVM_CTRL_ALPHA +: DVM_ALPHA_W];

  always_comb begin
    st_d = st_q;
    case (st_q)
      DVM_IDLE:  if (start_ok) st_d = DVM_PASS;
      DVM_PASS:  if (end_frm) st_d = (en2 && !b_eop) ? DVM_DRAIN : DVM_GAP;
      DVM_DRAIN: if (drop_b && second_video_input_eop) st_d = DVM_GAP;
      DVM_GAP:   if (gap_q == GW'(DVM_GAP_CYCLES)) st_d = DVM_IDLE;
      default:   st_d = DVM_IDLE;
    endcase
  end

  wire [GW-1:0] gap_d = (st_q == DVM_GAP) ? gap_q + GW'(1) : '0;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_q <= DVM_IDLE;
    end else begin
      st_q <= st_d;
    end
  end

  // Counts the stall cycles between packets; cleared outside the gap
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      gap_q <= '0;
    end else begin
      gap_q <= gap_d;
    end
  end

  // Ready flops are high through a packet; first input's drops outside PASS, second's in IDLE/GAP and whenever en2 is clear
  wire a_rdy_d = (st_d == DVM_PASS);
  wire b_rdy_d = en2 && (st_d == DVM_PASS || st_d == DVM_DRAIN);
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      a_ready_q <= 1'b0;
      b_ready_q <= 1'b0;
    end else begin
      a_ready_q <= a_rdy_d;
      b_ready_q <= b_rdy_d;
    end
  end
  // Ready is a gated flop: a pure flop ready would need a skid word on each input
  wire a_gate = out_free && (!en2 || second_video_input_valid);
  wire b_gate = (st_q == DVM_DRAIN) || (out_free && first_video_input_valid);
  assign first_video_input_ready  = a_ready_q && a_gate;
  assign second_video_input_ready = b_ready_q && b_gate;

  // Output register; one word per joint beat sets the rate per port width
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      dout_valid_q <= 1'b0;
    end else if (mv) begin
      dout_valid_q <= 1'b1;
    end else if (dout_ready) begin
      dout_valid_q <= 1'b0;
    end
  end

  // Payload only loads on a joint beat, so it stands while stalled
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      dout_sop_q  <= 1'b0;
      dout_eop_q  <= 1'b0;
      dout_data_q <= '0;
    end else if (mv) begin
      dout_sop_q  <= first_video_input_sop;
      dout_eop_q  <= end_frm;
      dout_data_q <= bi.y;
    end
  end
  assign dout_data  = dout_data_q;
  assign dout_valid = dout_valid_q;
  assign dout_sop   = dout_sop_q;
  assign dout_eop   = dout_eop_q;

  // APB slave: one wait state, answers on second access cycle
  wire acc      = psel && penable && !pready_q;
  wire hit_ctrl = paddr == DVM_OFF_CTRL;
  wire hit_stat = paddr == DVM_OFF_STATUS;
  wire hit_cnt  = paddr == DVM_OFF_COUNT;
  wire hit_drop = paddr == DVM_OFF_DROPS;
  // Unmapped offsets answer with an error and read as zero
  wire mapped   = hit_ctrl || hit_stat || hit_cnt || hit_drop;
  wire [31:0] status_w = {30'h0, st_q};
  wire [31:0] rd_mux = hit_ctrl ? ctrl_q
                     : hit_stat ? status_w
                     : hit_cnt  ? frames_q
                     : hit_drop ? drops_q : 32'h0;
  // Write lands on the completing edge, with pready already high
  wire wr_ctrl  = psel && penable && pready_q && pwrite && hit_ctrl;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= 32'h0;
    end else begin
      pready_q  <= acc;
      pslverr_q <= acc && !mapped;
      prdata_q  <= (acc && !pwrite) ? rd_mux : 32'h0;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ctrl_q <= DVM_CTRL_RST;
    end else if (wr_ctrl) begin
      ctrl_q <= pwdata;
    end
  end

  // Free-running statistics for software; they wrap silently
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      frames_q <= 32'h0;
    end else if (end_frm) begin
      frames_q <= frames_q + 32'h1;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      drops_q <= 32'h0;
    end else if (drop_b) begin
      drops_q <= drops_q + 32'h1;
    end
  end
  assign pready  = pready_q;
  assign pslverr = pslverr_q;
  assign prdata  = prdata_q;
endmodule

//--- logic/dvm_pkg.sv
// Purpose: shared constants and types for the two-input video mixer flow block
// Assumes: one synchronous clock, valid/ready streams
// Notes:   register map of the APB slave lives here
package dvm_pkg;
  localparam int unsigned DVM_PIX_BITS    = 8;
  localparam int unsigned DVM_PLANES      = 3;
  localparam int unsigned DVM_PIX_PER_BT  = 1;
  localparam logic [7:0]  DVM_OFF_CTRL    = 8'h00;
  localparam logic [7:0]  DVM_OFF_STATUS  = 8'h04;
  localparam logic [7:0]  DVM_OFF_COUNT   = 8'h08;
  localparam logic [7:0]  DVM_OFF_DROPS   = 8'h0C;
  localparam int unsigned DVM_CTRL_GO     = 0;
  localparam int unsigned DVM_CTRL_EN2    = 1;
  localparam int unsigned DVM_CTRL_ALPHA  = 8;
  localparam int unsigned DVM_ALPHA_W     = 8;
  localparam logic [31:0] DVM_CTRL_RST    = 32'h0000_8003;
  localparam int unsigned DVM_GAP_CYCLES  = 2;
  localparam logic [7:0]  DVM_TYPE_VIDEO  = 8'h00;
  typedef enum logic [1:0] {DVM_IDLE, DVM_PASS, DVM_DRAIN, DVM_GAP} dvm_state_t;
endpackage

//--- tb/dvm_mixer_assertions.sv
// Purpose: port checks on the mixer streams
// Assumes: one clock, async high reset
// Notes:   slot free means no output word is held back
`timescale 1ns/1ps
module dvm_mixer_assertions #(parameter int unsigned W = 24) (
  // Observed ports
  input wire logic         clk,
  input wire logic         rst,
  input wire logic         first_video_input_valid,
  input wire logic         first_video_input_ready,
  input wire logic         first_video_input_eop,
  input wire logic         second_video_input_valid,
  input wire logic         second_video_input_ready,
  input wire logic         second_video_input_eop,
  input wire logic [W-1:0] dout_data,
  input wire logic         dout_valid,
  input wire logic         dout_eop,
  input wire logic         dout_ready
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  wire fr = first_video_input_ready;
  wire sr = second_video_input_ready;
  wire fb = first_video_input_valid && fr;
  wire sb = second_video_input_valid && sr;
  wire ends = fb && (first_video_input_eop || sb && second_video_input_eop);
  sequence s_mid_beat; fb && !ends; endsequence
  sequence s_drain_beat; sb && !fr && !second_video_input_eop; endsequence
  a_first_beat: assert property (fb |=> dout_valid) else $error("beat lost");
  a_slot_free: assert property (fb |-> !dout_valid || dout_ready) else $error("slot full");
  a_eop_ends: assert property (ends |=> dout_eop) else $error("frame not ended");
  a_no_early_end: assert property (s_mid_beat |=> !dout_eop) else $error("early end");
  a_out_hold: assert property (dout_valid && !dout_ready |=> dout_valid && $stable(dout_data))
    else $error("output word dropped");
  a_drain_ready: assert property (s_drain_beat ##1 second_video_input_valid |-> sr)
    else $error("drain stalled");
  a_gap_after: assert property (fb && first_video_input_eop |=> !fr [*2])
    else $error("no gap after frame");
  a_no_stall: assert property (s_mid_beat ##1 (first_video_input_valid && sb) |-> fr)
    else $error("stall inside frame");
endmodule
bind dvm_mixer dvm_mixer_assertions #(.W(W)) u_dvm_mixer_assertions (
  .clk                      (clk),
  .rst                      (rst),
  .first_video_input_valid  (first_video_input_valid),
  .first_video_input_ready  (first_video_input_ready),
  .first_video_input_eop    (first_video_input_eop),
  .second_video_input_valid (second_video_input_valid),
  .second_video_input_ready (second_video_input_ready),
  .second_video_input_eop   (second_video_input_eop),
  .dout_data                (dout_data),
  .dout_valid               (dout_valid),
  .dout_eop                 (dout_eop),
  .dout_ready               (dout_ready)
);

//--- tb/dvm_mixer_tb.sv
// Purpose: self-checking bench for the two-input mixer
// Assumes: two sources and a toggling sink are the only traffic
// Notes:   blend values are checked only as a per-frame data sum, with word counts, starts and frame ends
`timescale 1ns/1ps
module dvm_mixer_tb;
  import dvm_pkg::*;
  logic        clk = 1'b0, rst = 1'b1, st = 1'b0, sk = 1'b0, sl = 1'b0, dout_ready = 1'b1;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr, perr;
  logic [7:0]  paddr = 8'h00, la = 8'h00, lb = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [23:0] da, db, dout_data;
  logic        va, ea, ra, ia, vb, eb, rb, ib, sopa, sopb, dout_valid, dout_sop, dout_eop;
  int          error_cnt = 0, n_compared = 0, n_out = 0, n_eop = 0, n_sop = 0;
  logic [31:0] sum_out = 32'h0;
  always #2 clk = ~clk;
  always @(posedge clk) begin
    dout_ready <= sk ? ~dout_ready : 1'b1;
    if (dout_valid && dout_ready) begin
      n_out <= n_out + 1;
      n_eop <= n_eop + int'(dout_eop);
      n_sop <= n_sop + int'(dout_sop);
      sum_out <= sum_out + 32'(dout_data);
    end
  end
  dvm_src u_dvm_src_a (.clk, .rst, .start(st), .slow(sl), .len(la), .idle(ia), .data(da),
    .valid(va), .sop(sopa), .eop(ea), .ready(ra));
  dvm_src u_dvm_src_b (.clk, .rst, .start(st), .slow(1'b0), .len(lb), .idle(ib), .data(db),
    .valid(vb), .sop(sopb), .eop(eb), .ready(rb));
  dvm_mixer u_dvm_mixer (.clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .pready,
    .prdata, .pslverr, .first_video_input_data(da), .first_video_input_valid(va),
    .first_video_input_sop(sopa), .first_video_input_eop(ea), .first_video_input_ready(ra),
    .second_video_input_data(db), .second_video_input_valid(vb), .second_video_input_sop(sopb),
    .second_video_input_eop(eb), .second_video_input_ready(rb), .dout_data, .dout_valid,
    .dout_sop, .dout_eop, .dout_ready);
  task automatic chk(input string nm, input logic [31:0] exp, got);
    n_compared++;
    if (got !== exp) begin
      $display("wrong value %s exp %h got %h", nm, exp, got);
      error_cnt++;
    end
  endtask
  task automatic tally_and_finish;
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    int k;
    k = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    rd = prdata;
    perr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (k >= 50) begin
      error_cnt++;
      tally_and_finish;
    end
  endtask
  task automatic t_regs;
    apb(1'b0, DVM_OFF_CTRL, 32'h0);
    chk("ctrl reset", DVM_CTRL_RST, rd);
    apb(1'b1, DVM_OFF_CTRL, 32'h0000_4003);
    apb(1'b0, DVM_OFF_CTRL, 32'h0);
    chk("ctrl", 32'h0000_4003, rd);
    apb(1'b0, 8'h10, 32'h0);
    chk("unmapped err", 32'h0000_0001, {31'h0, perr});
    $display("finished regs");
  endtask
  task automatic frame(input string nm, input logic [7:0] a, b, input logic s, input int x,
                       input logic [31:0] xs);
    int k, o, e, p;
    logic [31:0] q;
    o = n_out;
    e = n_eop;
    p = n_sop;
    q = sum_out;
    @(posedge clk);
    la <= a;
    lb <= b;
    sl <= s;
    sk <= s;
    st <= 1'b1;
    @(posedge clk);
    st <= 1'b0;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (!(ia && ib && !dout_valid) && k < 400);
    if (k >= 400) begin
      error_cnt++;
      tally_and_finish;
    end
    chk({nm, " words"}, 32'(x), 32'(n_out - o));
    chk({nm, " ends"}, 32'h1, 32'(n_eop - e));
    chk({nm, " starts"}, 32'h1, 32'(n_sop - p));
    chk({nm, " data sum"}, xs, sum_out - q);
    sk <= 1'b0;
    repeat (4) @(posedge clk);
    $display("finished %s", nm);
  endtask
  task automatic t_counts;
    apb(1'b0, DVM_OFF_COUNT, 32'h0);
    chk("frames", 32'h3, rd);
    apb(1'b0, DVM_OFF_DROPS, 32'h0);
    chk("drops", 32'h3, rd);
    apb(1'b0, DVM_OFF_STATUS, 32'h0);
    chk("status idle", 32'h0, rd);
    $display("finished counts");
  endtask
  initial begin
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    t_regs;
    frame("equal", 8'h04, 8'h04, 1'b0, 4, 32'h0000_000A);
    frame("first short", 8'h02, 8'h05, 1'b0, 2, 32'h0000_0003);
    frame("slow", 8'h06, 8'h06, 1'b1, 6, 32'h0000_0015);
    t_counts;
    tally_and_finish;
  end
endmodule

//--- tb/dvm_src.sv
// Purpose: upstream video source for one mixer input
// Assumes: valid/ready handshake, word count loaded on start
// Notes:   data is scrambled while no word is offered
`timescale 1ns/1ps
module dvm_src #(parameter int unsigned W = 24) (
  // Control
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic         start,
  input  wire logic         slow,
  input  wire logic [7:0]   len,
  output logic              idle,
  // Stream
  output logic [W-1:0]      data,
  output logic              valid,
  output logic              sop,
  output logic              eop,
  input  wire logic         ready
);
  logic [7:0] cnt_q;
  logic       rest_q;
  logic       first_q;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_q <= 8'h00;
      rest_q <= 1'b0;
      first_q <= 1'b0;
    end else begin
      rest_q <= slow && valid && ready;
      if (start) cnt_q <= len;
      else if (valid && ready) cnt_q <= cnt_q - 8'h01;
      if (start) first_q <= 1'b1;
      else if (valid && ready) first_q <= 1'b0;
    end
  end
  assign sop   = valid && first_q;
  assign idle  = (cnt_q == 8'h00);
  assign valid = !idle && !rest_q;
  assign eop   = valid && (cnt_q == 8'h01);
  assign data  = valid ? W'(cnt_q) : ~W'(cnt_q);
endmodule
